// ===== src/fpg_gpio_status.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Status and configuration of the four lines on the fan drive pins
// ****************************************************************
module fpg_gpio_status #(
    parameter int NUM_LINES = 4
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // Register port from the serial interface engine
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic                 reg_wr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_rd_i,
    output logic      [7:0]           reg_rdata_o,
    output logic                      reg_rvalid_o,
    // Per pin hand-over to GPIO use, from the enable register
    input  wire logic [NUM_LINES-1:0] gpio_en_i,
    // Fan drive pulses from the pulse generator
    input  wire logic [NUM_LINES-1:0] fan_pwm_i,
    // Fan drive pins, bit 0 is fan_drive_pin_1
    input  wire logic [NUM_LINES-1:0] fan_drive_pin_in_i,
    output logic      [NUM_LINES-1:0] fan_drive_pin_o,
    output logic      [NUM_LINES-1:0] fan_drive_pin_oe_o
);

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    // The 8-bit registers have room for exactly four lines
    if (NUM_LINES != 4) begin : g_bad_lines
        $error("fpg_gpio_status: NUM_LINES must be 4");
    end

    // ****************************************************************
    // Field decoding
    // ****************************************************************
    // Direction bit of a line in the configuration register
    function automatic logic line_dir(input logic [7:0] cfg, input int n);
        line_dir = cfg[fpg_pkg::DIR_MSB - fpg_pkg::FIELD_STRIDE * n];
    endfunction : line_dir

    // Polarity bit of a line, one below its direction bit
    function automatic logic line_pol(input logic [7:0] cfg, input int n);
        line_pol = cfg[fpg_pkg::DIR_MSB - fpg_pkg::FIELD_STRIDE * n - 1];
    endfunction : line_pol

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0]           config_ff;
    logic [7:0]           nxt_config;
    logic [7:0]           state_ff;
    logic [7:0]           nxt_state;
    logic [7:0]           rdata_ff;
    logic [7:0]           nxt_rdata;
    logic                 rvalid_ff;
    logic                 nxt_rvalid;
    logic [NUM_LINES-1:0] asserted;
    logic [NUM_LINES-1:0] line_dir_v;
    logic [NUM_LINES-1:0] line_pol_v;
    logic [NUM_LINES-1:0] line_state_v;

    logic wr_config;
    logic wr_state;

    assign wr_config = reg_wr_i && (reg_addr_i == fpg_pkg::LINE_CONFIG_ADDR);
    assign wr_state  = reg_wr_i && (reg_addr_i == fpg_pkg::LINE_STATE_ADDR);

    // Configuration register: plain read/write storage
    always_comb begin
        nxt_config = config_ff;
        if (wr_config) begin
            nxt_config = reg_wdata_i;
        end
    end

    // ****************************************************************
    // Line state register
    // ****************************************************************
    // Upper nibble per line; lower nibble is kept as plain test storage.
    // Input lines follow the pin every cycle, so a host write landing in
    // the same cycle cannot mask a fresh sample.
    always_comb begin
        nxt_state = state_ff;
        if (wr_state) begin
            nxt_state[fpg_pkg::TEST_BITS_W-1:0] = reg_wdata_i[fpg_pkg::TEST_BITS_W-1:0]; // see R6
        end
        for (int n = 0; n < NUM_LINES; n++) begin
            if (gpio_en_i[n]) begin // see R5
                if (line_dir(config_ff, n) == fpg_pkg::DIR_OUTPUT) begin // see R8
                    if (wr_state) begin
                        nxt_state[fpg_pkg::STATE_LSB + n] = reg_wdata_i[fpg_pkg::STATE_LSB + n]; // see R3 see R4
                    end
                end else begin
                    // Host writes never reach an input line
                    nxt_state[fpg_pkg::STATE_LSB + n] = asserted[n]; // see R1 see R11 see R4
                end
            end
            // Outside GPIO use the bit simply holds; it has no function then
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Data is registered one cycle after the read strobe
    always_comb begin
        nxt_rvalid = reg_rd_i;
        nxt_rdata  = rdata_ff;
        if (reg_rd_i) begin
            case (reg_addr_i)
                fpg_pkg::LINE_CONFIG_ADDR: begin
                    nxt_rdata = config_ff;
                end
                fpg_pkg::LINE_STATE_ADDR: begin
                    nxt_rdata = state_ff;
                end
                default: begin
                    nxt_rdata = fpg_pkg::UNMAPPED_RDATA;
                end
            endcase
        end
    end

    // Configuration register; cleared so every line starts as an active-low input
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_ff <= fpg_pkg::LINE_CONFIG_RST;
        end else begin
            config_ff <= nxt_config;
        end
    end

    // Line state register; cleared so no output line comes up asserted
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= fpg_pkg::LINE_STATE_RST; // see R7
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Read answer; cleared so a stale byte is never flagged valid after reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff  <= fpg_pkg::RDATA_RST;
            rvalid_ff <= fpg_pkg::RVALID_RST;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign reg_rdata_o  = rdata_ff;
    assign reg_rvalid_o = rvalid_ff;

    // ****************************************************************
    // Pin cells
    // ****************************************************************
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
        assign line_dir_v[g]   = line_dir(config_ff, g);
        assign line_pol_v[g]   = line_pol(config_ff, g);
        assign line_state_v[g] = state_ff[fpg_pkg::STATE_LSB + g];

        fpg_line u_line (
            .ref_clk_i  (ref_clk_i),
            .rst_n_i    (rst_n_i),
            .gpio_en_i  (gpio_en_i[g]),
            .dir_i      (line_dir_v[g]),
            .pol_i      (line_pol_v[g]),
            .state_i    (line_state_v[g]),
            .fan_pwm_i  (fan_pwm_i[g]),
            .pin_in_i   (fan_drive_pin_in_i[g]),
            .pin_o      (fan_drive_pin_o[g]),
            .pin_oe_o   (fan_drive_pin_oe_o[g]),
            .asserted_o (asserted[g])
        );
    end

endmodule : fpg_gpio_status
`default_nettype wire

// ===== src/fpg_pkg.sv
// Overview of operation
// R1 - Input line: status bit is read-only and set while the pin is asserted.
// R2 - Each line's polarity decides whether asserted means high or low.
// R3 - Output line: status bit is writable; a one drives the pin asserted.
// R4 - Status bits 7 to 4 hold lines four, three, two and one.
// R5 - A status bit only means something while its pin is in GPIO use.
// R6 - Software leaves status bits 3 to 0 alone; they are test bits.
// R7 - The whole status register clears to zero at power-up.
// R8 - Direction setting one selects output, zero selects input.
// R9 - Polarity setting one selects active high, zero selects active low.
// R10 - A per-pin enable takes the fan drive pulse off the pin for GPIO use.
// R11 - Writes to the status bit of an input line are ignored.
package fpg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] LINE_CONFIG_ADDR = 8'h80;
    localparam logic [7:0] LINE_STATE_ADDR  = 8'h81;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    // Line n (0 = line one) has its state bit at STATE_LSB + n
    localparam int STATE_LSB     = 4;
    // Line n has direction at DIR_MSB - 2n and polarity one below it
    localparam int DIR_MSB       = 7;
    localparam int FIELD_STRIDE  = 2;
    localparam int TEST_BITS_W   = 4;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [7:0] LINE_CONFIG_RST = 8'h00;
    localparam logic [7:0] LINE_STATE_RST  = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;
    localparam logic [7:0] RDATA_RST       = 8'h00;
    localparam logic       RVALID_RST      = 1'b0;
    localparam logic       DIR_OUTPUT      = 1'b1;
    localparam logic       POL_ACT_HIGH    = 1'b1;

endpackage : fpg_pkg

// ===== src/fpg_line.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// One shared pin: fan drive pulse or general purpose line
// ****************************************************************
module fpg_line (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Settings of this line
    input  wire logic gpio_en_i,
    input  wire logic dir_i,
    input  wire logic pol_i,
    input  wire logic state_i,
    // Fan drive pulse from the pulse generator
    input  wire logic fan_pwm_i,
    // Pin
    input  wire logic pin_in_i,
    output logic      pin_o,
    output logic      pin_oe_o,
    // Pin seen through the polarity setting
    output logic      asserted_o
);

    logic nxt_pin;
    logic nxt_oe;
    logic pin_ff;
    logic oe_ff;

    // Asserted level follows polarity; pin inputs are already synchronous
    assign asserted_o = (pol_i == fpg_pkg::POL_ACT_HIGH) ? pin_in_i : ~pin_in_i; // see R2 see R9

    // Pin owner: pulse generator unless the line is handed to GPIO use
    always_comb begin
        nxt_pin = fan_pwm_i;
        nxt_oe  = 1'b1;
        if (gpio_en_i) begin // see R10
            if (dir_i == fpg_pkg::DIR_OUTPUT) begin // see R8
                // A stored one drives the asserted level
                nxt_pin = (pol_i == fpg_pkg::POL_ACT_HIGH) ? state_i : ~state_i; // see R3 see R2
                nxt_oe  = 1'b1;
            end else begin
                // Released so the outside signal can be sensed
                nxt_pin = 1'b0;
                nxt_oe  = 1'b0;
            end
        end
    end

    // Registered pin drive; reset releases the pin
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
            oe_ff  <= nxt_oe;
        end
    end

    assign pin_o    = pin_ff;
    assign pin_oe_o = oe_ff;

endmodule : fpg_line
`default_nettype wire

// ===== sim/fpg_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Far side of the fan drive pins
// ****
module fpg_pin_model (
    // From the block
    input  wire logic [3:0] pin_o_i,
    input  wire logic [3:0] oe_i,
    // Board side
    input  wire logic [3:0] ext_i,
    output logic      [3:0] pin_in_o
);
    // A driven pin shows the block's level, a released one the board's
    assign pin_in_o = (pin_o_i & oe_i) | (ext_i & ~oe_i);
endmodule : fpg_pin_model
`default_nettype wire

// ===== sim/fpg_gpio_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker for the line status block
// ****
module fpg_gpio_status_chk #(
    parameter int NUM_LINES = 4
) (
    // Clock and reset
    input wire logic                 ref_clk_i,
    input wire logic                 rst_n_i,
    // Register port
    input wire logic [7:0]           reg_addr_i,
    input wire logic                 reg_wr_i,
    input wire logic [7:0]           reg_wdata_i,
    input wire logic                 reg_rd_i,
    input wire logic [7:0]           reg_rdata_o,
    input wire logic                 reg_rvalid_o,
    // Lines and pins
    input wire logic [NUM_LINES-1:0] gpio_en_i,
    input wire logic [NUM_LINES-1:0] fan_pwm_i,
    input wire logic [NUM_LINES-1:0] fan_drive_pin_in_i,
    input wire logic [NUM_LINES-1:0] fan_drive_pin_o,
    input wire logic [NUM_LINES-1:0] fan_drive_pin_oe_o
);
    // The shadow model below is written for exactly four lines
    if (NUM_LINES != 4) begin : g_bad_lines
        $error("fpg_gpio_status_chk: NUM_LINES must be 4");
    end
    logic [7:0] cfg_ff, st_ff, nxt_cfg, nxt_st;
    logic [3:0] dir_v, pol_v, in_v, out_v, oe_exp, pin_exp;
    // Line n: direction at bit 7-2n, polarity one below
    assign dir_v   = {cfg_ff[1], cfg_ff[3], cfg_ff[5], cfg_ff[7]};
    assign pol_v   = {cfg_ff[0], cfg_ff[2], cfg_ff[4], cfg_ff[6]};
    assign in_v    = gpio_en_i & ~dir_v;
    assign out_v   = gpio_en_i & dir_v;
    assign oe_exp  = ~gpio_en_i | dir_v;
    assign pin_exp = st_ff[7:4] ^ ~pol_v;
    // Shadow registers; a sampled input beats a host write
    always_comb begin
        nxt_cfg = (reg_wr_i && reg_addr_i == 8'h80) ? reg_wdata_i : cfg_ff;
        nxt_st  = st_ff;
        if (reg_wr_i && reg_addr_i == 8'h81)
            nxt_st = {(reg_wdata_i[7:4] & out_v) | (st_ff[7:4] & ~out_v), reg_wdata_i[3:0]};
        nxt_st[7:4] = (nxt_st[7:4] & ~in_v) | (~(fan_drive_pin_in_i ^ pol_v) & in_v);
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_ff <= 8'h00;
            st_ff  <= 8'h00;
        end else begin
            cfg_ff <= nxt_cfg;
            st_ff  <= nxt_st;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_RD_VALID: assert property (reg_rd_i |-> ##1 reg_rvalid_o)
        else $error("read not answered");
    AST_RD_STATE: assert property (reg_rd_i && reg_addr_i == 8'h81 |=> reg_rdata_o == $past(st_ff))
        else $error("state read wrong");
    AST_RD_CONFIG: assert property (reg_rd_i && reg_addr_i == 8'h80 |=> reg_rdata_o == $past(cfg_ff))
        else $error("config read wrong");
    AST_RD_UNMAPPED: assert property (reg_rd_i && reg_addr_i[7:1] != 7'h40 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Reset sampled high at the start keeps the first edge after release out of these checks
    AST_RDATA_HOLD: assert property (rst_n_i && !reg_rd_i |=> $stable(reg_rdata_o) && !reg_rvalid_o)
        else $error("read data moved");
    AST_OE: assert property (rst_n_i |=> fan_drive_pin_oe_o == $past(oe_exp))
        else $error("pin enable wrong");
    AST_PIN_OUT: assert property (rst_n_i |=> ((fan_drive_pin_o ^ $past(pin_exp)) & $past(out_v)) == 4'h0)
        else $error("output level wrong");
    AST_PWM_PASS: assert property (rst_n_i |=> ((fan_drive_pin_o ^ $past(fan_pwm_i)) & ~$past(gpio_en_i)) == 4'h0)
        else $error("fan pulse not passed");
endmodule : fpg_gpio_status_chk
bind fpg_gpio_status fpg_gpio_status_chk #(.NUM_LINES(NUM_LINES)) i_chk (
    .ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .gpio_en_i, .fan_pwm_i, .fan_drive_pin_in_i, .fan_drive_pin_o, .fan_drive_pin_oe_o
);
`default_nettype wire

// ===== sim/fpg_gpio_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench for the line status block
// ****
module fpg_gpio_status_tb;
    typedef struct packed {
        logic [3:0] en, ext, pwm, pin, oe;
        logic [7:0] cfg, wr, st;
    } fpg_row_t;
    logic       clk, rst_n, wr, rd, rvalid;
    logic [7:0] addr, wdata, rdata, d;
    logic [3:0] en, pwm, ext, pin, oe, pin_in;
    int         n_errors = 0;
    int         n_compared = 0;
    // Rows: out high, out low, in high, in low, fan use, mixed
    fpg_row_t   rows[6] = '{
        '{4'hf, 4'h0, 4'h0, 4'ha, 4'hf, 8'hff, 8'ha0, 8'ha0},
        '{4'hf, 4'h0, 4'h0, 4'ha, 4'hf, 8'haa, 8'h50, 8'h50},
        '{4'hf, 4'h6, 4'h0, 4'h0, 4'h0, 8'h55, 8'hf0, 8'h60},
        '{4'hf, 4'h6, 4'h0, 4'h0, 4'h0, 8'h00, 8'hf0, 8'h90},
        '{4'h0, 4'h6, 4'h3, 4'h3, 4'hf, 8'hff, 8'h50, 8'h90},
        '{4'h3, 4'h2, 4'h4, 4'h5, 4'hd, 8'hd0, 8'hf0, 8'hb0}};
    fpg_gpio_status i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .gpio_en_i(en),
        .fan_pwm_i(pwm), .fan_drive_pin_in_i(pin_in), .fan_drive_pin_o(pin), .fan_drive_pin_oe_o(oe));
    fpg_pin_model i_pins (.pin_o_i(pin), .oe_i(oe), .ext_i(ext), .pin_in_o(pin_in));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Pin drive and enable vectors
    task automatic chk_pins(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pins
    // Single handshake flags
    task automatic chk_flag(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_flag
    // One strobe; a read also returns the answered byte
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= w;
        rd    <= !w;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        #1;
        d = rdata;
        if (!w) chk_flag("rvalid", 1'b1, rvalid);
    endtask : acc
    task automatic print_verdict();
        $display("Compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is under sixty cycles
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end
    initial begin
        {rst_n, wr, rd, addr, wdata, en, pwm, ext} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            en  <= rows[i].en;
            pwm <= rows[i].pwm;
            ext <= rows[i].ext;
            acc(1'b1, 8'h80, rows[i].cfg);
            acc(1'b1, 8'h81, rows[i].wr);
            acc(1'b0, 8'h81, 8'h00);
            chk("state", rows[i].st, d);
            chk_pins("pin", rows[i].pin, pin);
            chk_pins("oe", rows[i].oe, oe);
        end
        // Read and write on one edge: the read sees the older byte
        @(posedge clk);
        addr  <= 8'h81;
        wdata <= 8'h00;
        wr    <= 1'b1;
        rd    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        ext   <= 4'h0;
        #1;
        chk("rd_with_wr", 8'hb0, rdata);
        acc(1'b0, 8'h81, 8'h00);
        chk("pin_follow", 8'h80, d);
        acc(1'b0, 8'h80, 8'h00);
        chk("config", 8'hd0, d);
        acc(1'b0, 8'h7f, 8'h00);
        chk("unmapped", fpg_pkg::UNMAPPED_RDATA, d);
        // Reset in mid-run releases pins and clears the state register
        @(posedge clk);
        en    <= 4'h0;
        rst_n <= 1'b0;
        #1;
        chk_pins("oe_rst", 4'h0, oe);
        chk_pins("pin_rst", 4'h0, pin);
        @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b0, 8'h81, 8'h00);
        chk("state_rst", 8'h00, d);
        print_verdict();
    end
endmodule : fpg_gpio_status_tb
`default_nettype wire
